//--- design/dep_param_bank.sv
// Purpose: Parameter register bank of the 2D drawing engine.
// Assumes: The host reaches the bank through its memory-mapped window;
//          command and addressing selects come from the engine's own registers.
// Notes:   Parameters are frozen at engine activation for the whole operation.
//
// How it works
// - Line uses source X bits 13:0 as step.
// - Host blit uses source X bits 2:0 alignment.
// - X-Y mode: destination Y is 12-bit row.
// - Linear: destination Y gives address bits 23:12.
// - Linear: destination X gives address bits 11:0.
// - X-Y mode: destination X bits 11:0 column.
// - Line start Y from destination Y.
// - Line start X from destination X.
// - Rectangle height from offset 08h bits 11:0.
// - Rectangle width from offset 0Ah bits 11:0.
// - Height is plain rows, never tripled.
// - Offset 08h holds 14-bit line error term.
// - Offset 0Ah holds line vector length.
// - Non-horizontal stroke length from offset 08h.
// - Horizontal stroke length from offset 0Ah.
// - Contents undefined at power-on; program before use.
`include "dep_map.svh"
module dep_param_bank (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire dep_pkg::dep_bus_t bus,
  input  wire dep_pkg::dep_mode_t mode,
  input  wire logic              engine_start,
  input  wire logic              engine_done,
  output logic [15:0]            reg_rdata,
  output logic                   op_busy,
  output dep_pkg::dep_op_t       op
);
  import dep_pkg::*;

  typedef struct packed {
    dep_bank_t   bank;
    dep_op_t     op;
    logic        busy;
    logic [15:0] rdata;
  } dep_state_t;

  dep_state_t state_reg;
  dep_state_t state_next;
  dep_op_t    live_op;
  logic       take;

  // -----------------------------------------------------------------
  // Decode of the live bank
  // -----------------------------------------------------------------
  dep_param_decode u_decode (
    .bank (state_reg.bank),
    .mode (mode),
    .op   (live_op)
  );

  // A start while busy is ignored; a start in the cycle of done is taken.
  assign take = engine_start && (!state_reg.busy || engine_done);

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  // Writes to mapped offsets land in the bank even while busy, but the engine only ever reads the
  // snapshot, so rewriting parameters mid-operation is harmless.
  always_comb begin
    state_next = state_reg;
    if (bus.wr) begin
      case (bus.addr)
        `DEP_OFF_SRCX: state_next.bank.src_x = bus.wdata & `DEP_MASK_14;
        `DEP_OFF_DSTY: state_next.bank.dst_y = bus.wdata & `DEP_MASK_14;
        `DEP_OFF_DSTX: state_next.bank.dst_x = bus.wdata & `DEP_MASK_12;
        `DEP_OFF_DIMY: state_next.bank.dim_y = bus.wdata & `DEP_MASK_14;
        `DEP_OFF_DIMX: state_next.bank.dim_x = bus.wdata & `DEP_MASK_12;
        default:       state_next.bank = state_reg.bank;
      endcase
    end
    // Read data is registered; unmapped offsets read as zero.
    if (bus.rd) begin
      case (bus.addr)
        `DEP_OFF_SRCX: state_next.rdata = state_reg.bank.src_x;
        `DEP_OFF_DSTY: state_next.rdata = state_reg.bank.dst_y;
        `DEP_OFF_DSTX: state_next.rdata = state_reg.bank.dst_x;
        `DEP_OFF_DIMY: state_next.rdata = state_reg.bank.dim_y;
        `DEP_OFF_DIMX: state_next.rdata = state_reg.bank.dim_x;
        default:       state_next.rdata = `DEP_RST_VAL;
      endcase
    end
    // Snapshot at activation; held until the next accepted start.
    if (take) begin
      state_next.op   = live_op;
      state_next.busy = 1'b1;
    end else if (engine_done) begin
      state_next.busy = 1'b0;
    end
    // Contents are undefined to software; zero only gives the model a
    // known value and must not be relied upon.
    if (sys_rst) begin
      state_next.bank  = '0;
      state_next.op    = '0;
      state_next.busy  = 1'b0;
      state_next.rdata = `DEP_RST_VAL;
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    state_reg <= state_next;
  end

  // Outputs straight from flip-flops.
  assign reg_rdata = state_reg.rdata;
  assign op_busy   = state_reg.busy;
  assign op        = state_reg.op;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  a_line_step: assert property (
    @(posedge clock) disable iff (sys_rst)
    (take && mode.func == `DEP_FN_LINE)
    |=> op.axial_step_constant == $past(state_reg.bank.src_x[13:0]))
  else $error("Step constant not captured from source X.");

  a_hblit_align: assert property (
    @(posedge clock) disable iff (sys_rst)
    (take && mode.func == `DEP_FN_HBLIT)
    |=> op.is_hblit && op.host_mono_align == $past(state_reg.bank.src_x[2:0]))
  else $error("Mono alignment not captured from source X.");

  a_xy_row_col: assert property (
    @(posedge clock) disable iff (sys_rst)
    (take && mode.addr_sel[3:2] != 2'h3 && mode.func != `DEP_FN_LINE)
    |=> op.dest_row == $past(state_reg.bank.dst_y[11:0])
        && op.dest_col == $past(state_reg.bank.dst_x[11:0]) && !op.linear)
  else $error("X-Y destination not captured.");

  a_linear_addr: assert property (
    @(posedge clock) disable iff (sys_rst)
    (take && mode.addr_sel[3:2] == 2'h3)
    |=> op.linear && op.dest_linear_address
        == {$past(state_reg.bank.dst_y[11:0]), $past(state_reg.bank.dst_x[11:0])})
  else $error("Linear destination address wrong.");

  a_line_start: assert property (
    @(posedge clock) disable iff (sys_rst)
    (take && mode.func == `DEP_FN_LINE)
    |=> op.start_y == $past(state_reg.bank.dst_y[11:0])
        && op.start_x == $past(state_reg.bank.dst_x[11:0]))
  else $error("Line start point not captured.");

  a_rect_dims: assert property (
    @(posedge clock) disable iff (sys_rst)
    (take && mode.func != `DEP_FN_LINE && mode.func != `DEP_FN_STROKE)
    |=> op.rect_height == $past(state_reg.bank.dim_y[11:0])
        && op.rect_width == $past(state_reg.bank.dim_x[11:0]))
  else $error("Rectangle size not captured.");

  a_line_terms: assert property (
    @(posedge clock) disable iff (sys_rst)
    (take && mode.func == `DEP_FN_LINE)
    |=> op.line_error_term == $past(state_reg.bank.dim_y[13:0])
        && op.vector_length == $past(state_reg.bank.dim_x[11:0]))
  else $error("Line error term or length not captured.");

  a_stroke_len: assert property (
    @(posedge clock) disable iff (sys_rst)
    (take && mode.func == `DEP_FN_STROKE)
    |=> op.stroke_len_vert == $past(state_reg.bank.dim_y[11:0])
        && op.stroke_len_horiz == $past(state_reg.bank.dim_x[11:0]))
  else $error("Stroke lengths not captured.");

  a_op_frozen: assert property (
    @(posedge clock) disable iff (sys_rst)
    (op_busy && !take) |=> $stable(op))
  else $error("Operation parameters changed without a new start.");

  a_busy_clear: assert property (
    @(posedge clock) disable iff (sys_rst)
    (op_busy && engine_done && !engine_start) |=> !op_busy)
  else $error("Busy not cleared by done.");

  a_reset_idle: assert property (
    @(posedge clock)
    sys_rst |=> !op_busy && reg_rdata == 16'h0000)
  else $error("Bank not idle after reset.");

  a_read_back: assert property (
    @(posedge clock) disable iff (sys_rst)
    (bus.rd && bus.addr == `DEP_OFF_DIMY) |=> reg_rdata == $past(state_reg.bank.dim_y))
  else $error("Read of height register returned wrong data.");
endmodule

//--- design/dep_map.svh
// Purpose: Offsets, masks, codes and reset values of the parameter bank.
// Assumes: Offsets are byte offsets from the engine register base.
// Notes:   Definitions only.
`ifndef DEP_MAP_SVH
`define DEP_MAP_SVH
// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define DEP_OFF_SRCX   6'h02
`define DEP_OFF_DSTY   6'h04
`define DEP_OFF_DSTX   6'h06
`define DEP_OFF_DIMY   6'h08
`define DEP_OFF_DIMX   6'h0A
// -----------------------------------------------------------------
// Implemented bits and reset values
// -----------------------------------------------------------------
`define DEP_MASK_14    16'h3FFF
`define DEP_MASK_12    16'h0FFF
`define DEP_RST_VAL    16'h0000
// -----------------------------------------------------------------
// Command function codes and the linear addressing select
// -----------------------------------------------------------------
`define DEP_FN_STROKE  4'h6
`define DEP_FN_LINE    4'h7
`define DEP_FN_HBLIT   4'h8
`define DEP_LIN_SEL    2'h3
`define DEP_LIN_MSB    3
`define DEP_LIN_LSB    2
`endif

//--- design/dep_pkg.sv
// Purpose: Types shared by the parameter bank and its decoder.
// Assumes: Nothing beyond the map header.
// Notes:   Types only; numbers live in dep_map.svh.
package dep_pkg;
  // -----------------------------------------------------------------
  // Carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } dep_bus_t;

  typedef struct packed {
    logic [3:0] func;
    logic [3:0] addr_sel;
  } dep_mode_t;

  typedef struct packed {
    logic [15:0] src_x;
    logic [15:0] dst_y;
    logic [15:0] dst_x;
    logic [15:0] dim_y;
    logic [15:0] dim_x;
  } dep_bank_t;

  typedef struct packed {
    logic        is_line;
    logic        is_stroke;
    logic        is_hblit;
    logic        linear;
    logic [23:0] dest_linear_address;
    logic [11:0] dest_row;
    logic [11:0] dest_col;
    logic [11:0] start_y;
    logic [11:0] start_x;
    logic [13:0] axial_step_constant;
    logic [2:0]  host_mono_align;
    logic [11:0] rect_height;
    logic [11:0] rect_width;
    logic [13:0] line_error_term;
    logic [11:0] vector_length;
    logic [11:0] stroke_len_vert;
    logic [11:0] stroke_len_horiz;
  } dep_op_t;
endpackage

//--- design/dep_param_decode.sv
// Purpose: Interprets the raw parameter words for the selected function.
// Assumes: Function and addressing select come from the command logic.
// Notes:   Purely combinational; the bank registers its result.
`include "dep_map.svh"
module dep_param_decode (
  input  wire dep_pkg::dep_bank_t bank,
  input  wire dep_pkg::dep_mode_t mode,
  output dep_pkg::dep_op_t        op
);
  import dep_pkg::*;

  logic is_line;
  logic is_stroke;
  logic is_hblit;
  logic is_rect;
  logic linear;

  // Function and addressing decode.
  assign is_line   = (mode.func == `DEP_FN_LINE);
  assign is_stroke = (mode.func == `DEP_FN_STROKE);
  assign is_hblit  = (mode.func == `DEP_FN_HBLIT);
  assign is_rect   = !(is_line || is_stroke);
  assign linear    = (mode.addr_sel[`DEP_LIN_MSB:`DEP_LIN_LSB] == `DEP_LIN_SEL);

  // Unused meanings are forced to zero so the engine never sees stale fields.
  always_comb begin
    op                     = '0;
    op.is_line             = is_line;
    op.is_stroke           = is_stroke;
    op.is_hblit            = is_hblit;
    op.linear              = linear;
    op.dest_linear_address = linear ? {bank.dst_y[11:0], bank.dst_x[11:0]} : 24'h000000;
    op.dest_row            = (!linear && !is_line) ? bank.dst_y[11:0] : 12'h000;
    op.dest_col            = (!linear && !is_line) ? bank.dst_x[11:0] : 12'h000;
    op.start_y             = is_line ? bank.dst_y[11:0] : 12'h000;
    op.start_x             = is_line ? bank.dst_x[11:0] : 12'h000;
    op.axial_step_constant = is_line ? bank.src_x[13:0] : 14'h0000;
    op.host_mono_align     = is_hblit ? bank.src_x[2:0] : 3'h0;
    // Height is taken as plain rows; no tripling in packed 24-bit modes.
    op.rect_height         = is_rect ? bank.dim_y[11:0] : 12'h000;
    op.rect_width          = is_rect ? bank.dim_x[11:0] : 12'h000;
    op.line_error_term     = is_line ? bank.dim_y[13:0] : 14'h0000;
    op.vector_length       = is_line ? bank.dim_x[11:0] : 12'h000;
    op.stroke_len_vert     = is_stroke ? bank.dim_y[11:0] : 12'h000;
    op.stroke_len_horiz    = is_stroke ? bank.dim_x[11:0] : 12'h000;
  end
endmodule

//--- tb/dep_param_bank_bench.sv
// Purpose: Self-checking bench for the drawing engine parameter bank.
// Assumes: Synchronous active-high reset; inputs change on falling edges.
// Notes:   Expected values come from field widths worked out here.
module dep_param_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dep_pkg::*;
  // ---------------------------------------------------------------
  // Signals and design under test
  // ---------------------------------------------------------------
  logic        clock;
  logic        sys_rst;
  dep_bus_t    bus;
  dep_mode_t   mode;
  logic        engine_start;
  logic        engine_done;
  logic [15:0] reg_rdata;
  logic        op_busy;
  dep_op_t     op;
  int          n_mismatch;
  int          comparisons;

  dep_param_bank dut_u (.clock(clock), .sys_rst(sys_rst), .bus(bus), .mode(mode),
    .engine_start(engine_start), .engine_done(engine_done), .reg_rdata(reg_rdata),
    .op_busy(op_busy), .op(op));

  // Free-running 8 ns clock.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe; the idle cycle after it keeps strobes apart.
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clock);
    bus = '{a, 1'b1, 1'b0, d};
    @(negedge clock);
    bus.wr = 1'b0;
  endtask

  // Read data is registered, so it is judged one cycle after the strobe.
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    @(negedge clock);
    bus = '{a, 1'b0, 1'b1, 16'h0000};
    @(negedge clock);
    bus.rd = 1'b0;
    chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask

  task automatic load(input logic [15:0] sx, dy, dx, hy, wx);
    wr(6'h02, sx);
    wr(6'h04, dy);
    wr(6'h06, dx);
    wr(6'h08, hy);
    wr(6'h0A, wx);
  endtask

  task automatic go(input logic [3:0] f, input logic [3:0] s);
    @(negedge clock);
    mode = '{f, s};
    engine_start = 1'b1;
    @(negedge clock);
    engine_start = 1'b0;
  endtask

  task automatic fin;
    @(negedge clock);
    engine_done = 1'b1;
    @(negedge clock);
    engine_done = 1'b0;
    chk("op_busy", {23'h000000, op_busy}, 24'h000000);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [5:0]  offs [5] = '{6'h02, 6'h04, 6'h06, 6'h08, 6'h0A};
    logic [15:0] msk  [5] = '{16'h3FFF, 16'h3FFF, 16'h0FFF, 16'h3FFF, 16'h0FFF};
    for (int i = 0; i < 5; i++) begin
      rd(offs[i], 16'h0000);
      wr(offs[i], 16'hFFFF);
      rd(offs[i], msk[i]);
    end
    wr(6'h10, 16'h1234);
    rd(6'h10, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_line;
    load(16'h2ABC, 16'h0345, 16'h0678, 16'h3001, 16'h0ABC);
    go(4'h7, 4'h0);
    chk("busy", {23'h000000, op_busy}, 24'h000001);
    chk("step", {10'h000, op.axial_step_constant}, 24'h002ABC);
    chk("start_y", {12'h000, op.start_y}, 24'h000345);
    chk("start_x", {12'h000, op.start_x}, 24'h000678);
    chk("err", {10'h000, op.line_error_term}, 24'h003001);
    chk("vlen", {12'h000, op.vector_length}, 24'h000ABC);
    chk("is_line", {23'h000000, op.is_line}, 24'h000001);
    chk("row_in_line", {12'h000, op.dest_row}, 24'h000000);
    fin();
    $display("test line done");
  endtask

  task automatic t_rect;
    load(16'h0000, 16'h0123, 16'h0456, 16'h0FFF, 16'h0801);
    go(4'h0, 4'hB);
    chk("linear", {23'h000000, op.linear}, 24'h000000);
    chk("row", {12'h000, op.dest_row}, 24'h000123);
    chk("col", {12'h000, op.dest_col}, 24'h000456);
    chk("height", {12'h000, op.rect_height}, 24'h000FFF);
    chk("width", {12'h000, op.rect_width}, 24'h000801);
    fin();
    go(4'h0, 4'hF);
    chk("lin_addr", op.dest_linear_address, 24'h123456);
    chk("linear_on", {23'h000000, op.linear}, 24'h000001);
    chk("row_in_lin", {12'h000, op.dest_row}, 24'h000000);
    fin();
    // A 24-bit packed fill of row 41h, column 100h, width 10h, height 20h.
    // Software triples row, column and width itself and leaves the height
    // alone, so the bank must hand all four on without any scaling.
    load(16'h0000, 16'h00C3, 16'h0300, 16'h0020, 16'h0030);
    go(4'h0, 4'h0);
    chk("row_x3", {12'h000, op.dest_row}, 24'h0000C3);
    chk("col_x3", {12'h000, op.dest_col}, 24'h000300);
    chk("height_24", {12'h000, op.rect_height}, 24'h000020);
    chk("width_x3", {12'h000, op.rect_width}, 24'h000030);
    fin();
    $display("test rect done");
  endtask

  task automatic t_stroke;
    load(16'hFFFD, 16'h0000, 16'h0000, 16'h0012, 16'h0034);
    go(4'h6, 4'h0);
    chk("len_v", {12'h000, op.stroke_len_vert}, 24'h000012);
    chk("len_h", {12'h000, op.stroke_len_horiz}, 24'h000034);
    chk("is_stroke", {23'h000000, op.is_stroke}, 24'h000001);
    fin();
    go(4'h8, 4'h0);
    chk("align", {21'h000000, op.host_mono_align}, 24'h000005);
    chk("is_hblit", {23'h000000, op.is_hblit}, 24'h000001);
    fin();
    // In 24-bit colour the host pre-aligns its mono data and leaves the
    // alignment field at zero, since the engine cannot help in that mode.
    wr(6'h02, 16'h0000);
    go(4'h8, 4'h0);
    chk("align_24", {21'h000000, op.host_mono_align}, 24'h000000);
    fin();
    $display("test stroke done");
  endtask

  // Writes and a second start during an operation must not disturb it.
  task automatic t_freeze;
    load(16'h0000, 16'h0001, 16'h0002, 16'h0333, 16'h0444);
    go(4'h0, 4'h0);
    wr(6'h08, 16'h0555);
    chk("frozen", {12'h000, op.rect_height}, 24'h000333);
    go(4'h0, 4'h0);
    chk("refused", {12'h000, op.rect_height}, 24'h000333);
    fin();
    go(4'h0, 4'h0);
    chk("new", {12'h000, op.rect_height}, 24'h000555);
    // A start in the very cycle of done is taken and picks up new values.
    wr(6'h08, 16'h0666);
    @(negedge clock);
    engine_start = 1'b1;
    engine_done = 1'b1;
    @(negedge clock);
    engine_start = 1'b0;
    engine_done = 1'b0;
    chk("restart_busy", {23'h000000, op_busy}, 24'h000001);
    chk("restart", {12'h000, op.rect_height}, 24'h000666);
    fin();
    $display("test freeze done");
  endtask

  // A reset in mid-operation drops the snapshot and clears the bank.
  task automatic t_reset;
    load(16'h0000, 16'h0011, 16'h0022, 16'h0033, 16'h0044);
    go(4'h0, 4'h0);
    @(negedge clock);
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    chk("rst_busy", {23'h000000, op_busy}, 24'h000000);
    chk("rst_height", {12'h000, op.rect_height}, 24'h000000);
    rd(6'h08, 16'h0000);
    $display("test reset done");
  endtask
  // ---------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence; the run is about 150 cycles long.
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    bus = '{6'h00, 1'b0, 1'b0, 16'h0000};
    mode = '{4'h0, 4'h0};
    engine_start = 1'b0;
    engine_done = 1'b0;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    t_regs();
    t_line();
    t_rect();
    t_stroke();
    t_freeze();
    t_reset();
    tally_and_finish();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    #(4000 * 8);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
